// file: src/stall_counter_defs.vh
`ifndef STALL_COUNTER_DEFS_VH
`define STALL_COUNTER_DEFS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define ADDR_CONTROL 2'h0
`define ADDR_FLAGS 2'h1
`define ADDR_COUNT 2'h2

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BIT_UNDERFLOW_IE 7
`define BIT_RELOAD_MODE 6
`define BIT_READ_LOAD 5
`define BIT_PRESCALE 4
`define BIT_FORCE_LOAD 3
`define BIT_COUNT_EN 2
`define BIT_OVERFLOW_IE 0
`define CONTROL_WMASK 8'hF5

// ----------------------------------------
// Flag register fields
// ----------------------------------------
`define BIT_UNDERFLOW_FLAG 7
`define BIT_OVERFLOW_FLAG 0

// ----------------------------------------
// Counter values and prescale counts
// ----------------------------------------
`define COUNT_PRESET 16'hFFFF
`define COUNT_ZERO 16'h0000
`define CONTROL_RESET 8'h00
`define PRESCALE_DIV_FAST 64
`define PRESCALE_DIV_SLOW 512

`endif

// file: src/prescale_divider.v
`timescale 1ns/100ps
`include "stall_counter_defs.vh"

module prescale_divider #(
  parameter DIV_FAST = `PRESCALE_DIV_FAST,
  parameter DIV_SLOW = `PRESCALE_DIV_SLOW
) (
  input wire i_clk, // Bus clock
  input wire i_rst, // Synchronous reset
  input wire i_restart, // Restart count from zero
  input wire i_slow, // Select slow division
  output reg o_tick // One-cycle tick
);

  // Terminal counts, cut to the counter width on purpose
  localparam integer LAST_FAST = DIV_FAST - 1;
  localparam integer LAST_SLOW = DIV_SLOW - 1;

  reg [9:0] count_q;
  wire [9:0] last_fast = LAST_FAST[9:0];
  wire [9:0] last_slow = LAST_SLOW[9:0];
  wire [9:0] last = i_slow ? last_slow : last_fast;

  // Free-running divider, tick on terminal count
  always @(posedge i_clk) begin
    if (i_rst || i_restart) begin
      count_q <= 10'h000;
      o_tick <= 1'b0;
    end else if (count_q >= last) begin
      count_q <= 10'h000;
      o_tick <= 1'b1;
    end else begin
      count_q <= count_q + 10'h001;
      o_tick <= 1'b0;
    end
  end

endmodule // prescale_divider

// file: src/sticky_flag.v
`timescale 1ns/100ps

module sticky_flag (
  input wire i_clk, // Bus clock
  input wire i_rst, // Synchronous reset
  input wire i_set, // Hardware event
  input wire i_clear, // Write-one-to-clear
  output reg o_flag // Sticky flag
);

  // Set wins over clear
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

endmodule // sticky_flag

// file: src/stall_detector_modulus_counter.v
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`include "stall_counter_defs.vh"

module stall_detector_modulus_counter #(
  parameter DIV_FAST = `PRESCALE_DIV_FAST,
  parameter DIV_SLOW = `PRESCALE_DIV_SLOW
) (
  input wire i_clk, // Bus clock, 250 MHz
  input wire i_rst, // Synchronous reset, active high
  input wire [1:0] i_addr, // Register index
  input wire [15:0] i_wdata, // Write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  input wire i_acc_overflow, // Accumulator overflow pulse, same clock
  output reg [15:0] o_rdata, // Read data, cycle after read
  output reg o_irq, // Level interrupt
  output reg [15:0] o_count, // Live counter value
  output reg o_underflow_flag, // Underflow flag copy
  output reg o_overflow_flag // Overflow flag copy
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] control_q;
  reg [15:0] count_q;
  reg [15:0] load_q;
  reg prescale_active_q;
  reg zero_hold_q;
  wire tick;
  wire underflow_flag;
  wire overflow_flag;

  wire wr_control = i_wr && (i_addr == `ADDR_CONTROL);
  wire wr_flags = i_wr && (i_addr == `ADDR_FLAGS);
  wire wr_count = i_wr && (i_addr == `ADDR_COUNT);
  wire force_load = wr_control && i_wdata[`BIT_FORCE_LOAD];
  wire count_en = control_q[`BIT_COUNT_EN];
  wire reload_mode = control_q[`BIT_RELOAD_MODE];
  wire load_event = force_load || (wr_count && !reload_mode);
  reg underflow_set;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Force load bit is never stored
  always @(posedge i_clk) begin
    if (i_rst) begin
      control_q <= `CONTROL_RESET;
    end else if (wr_control) begin
      control_q <= i_wdata[7:0] & `CONTROL_WMASK;
    end
  end

  // ----------------------------------------
  // Prescaler, selection latched on load
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      prescale_active_q <= 1'b0;
    end else if (load_event || (underflow_set && reload_mode)) begin
      prescale_active_q <= control_q[`BIT_PRESCALE];
    end
  end

  prescale_divider #(
    .DIV_FAST(DIV_FAST),
    .DIV_SLOW(DIV_SLOW)
  ) u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_restart(!count_en),
    .i_slow(prescale_active_q),
    .o_tick(tick)
  );

  // ----------------------------------------
  // Load register and down counter
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      load_q <= `COUNT_PRESET;
    end else if (wr_count) begin
      load_q <= i_wdata;
    end
  end

  // Underflow when a tick finds the counter at one, whether it then goes to zero or reloads
  always @* begin
    underflow_set = count_en && tick && !zero_hold_q && (count_q == 16'h0001);
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= `COUNT_PRESET;
      zero_hold_q <= 1'b0;
    end else if (!count_en && !(force_load && i_wdata[`BIT_COUNT_EN])) begin
      // A force load that also enables the counter still lands
      count_q <= `COUNT_PRESET;
      zero_hold_q <= 1'b0;
    end else if (force_load) begin
      count_q <= load_q;
      zero_hold_q <= (load_q == `COUNT_ZERO);
    end else if (wr_count && !reload_mode) begin
      count_q <= i_wdata;
      zero_hold_q <= (i_wdata == `COUNT_ZERO);
    end else if (tick && count_q != `COUNT_ZERO) begin
      if (count_q == 16'h0001 && reload_mode && load_q != `COUNT_ZERO) begin
        count_q <= load_q;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end else if (tick && reload_mode && load_q != `COUNT_ZERO) begin
      count_q <= load_q;
      zero_hold_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  sticky_flag u_underflow (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set(underflow_set),
    .i_clear(wr_flags && i_wdata[`BIT_UNDERFLOW_FLAG]),
    .o_flag(underflow_flag)
  );

  sticky_flag u_overflow (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set(i_acc_overflow),
    .i_clear(wr_flags && i_wdata[`BIT_OVERFLOW_FLAG]),
    .o_flag(overflow_flag)
  );

  // ----------------------------------------
  // Outputs and interrupt
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_count <= `COUNT_PRESET;
      o_underflow_flag <= 1'b0;
      o_overflow_flag <= 1'b0;
    end else begin
      o_irq <= (underflow_flag && control_q[`BIT_UNDERFLOW_IE]) ||
               (overflow_flag && control_q[`BIT_OVERFLOW_IE]);
      o_count <= count_q;
      o_underflow_flag <= underflow_flag;
      o_overflow_flag <= overflow_flag;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (!i_rd) begin
      o_rdata <= 16'h0000;
    end else if (i_addr == `ADDR_CONTROL) begin
      o_rdata <= {8'h00, control_q};
    end else if (i_addr == `ADDR_FLAGS) begin
      o_rdata <= {8'h00, underflow_flag, 6'h00, overflow_flag};
    end else if (i_addr == `ADDR_COUNT) begin
      o_rdata <= control_q[`BIT_READ_LOAD] ? load_q : count_q;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule // stall_detector_modulus_counter

// file: sim/stall_counter_chk.sv
`timescale 1ns/100ps
module stall_counter_chk #(
  parameter DIV_FAST = 64,
  parameter DIV_SLOW = 512
) (
  input wire i_clk, // Bus clock
  input wire i_rst, // Sync reset
  input wire [1:0] i_addr, // Index
  input wire [15:0] i_wdata, // Write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  input wire i_acc_overflow, // Overflow event
  input wire [15:0] o_rdata, // Read data
  input wire o_irq, // Interrupt
  input wire [15:0] o_count, // Counter
  input wire o_underflow_flag, // Underflow copy
  input wire o_overflow_flag // Overflow copy
);
  reg ue_q;
  reg oe_q;
  wire cause = (ue_q & o_underflow_flag) | (oe_q & o_overflow_flag);
  wire clr_uf = i_wr && i_addr == 2'h1 && i_wdata[7];
  // Mirror of the interrupt enables
  always @(posedge i_clk) begin
    if (i_rst) begin
      ue_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (i_wr && i_addr == 2'h0) begin
      ue_q <= i_wdata[7];
      oe_q <= i_wdata[0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero");
  AST_FORCE_ZERO: assert property (i_rd && i_addr == 2'h0 |=> !o_rdata[3])
    else $error("force load bit read one");
  AST_PRESET: assert property (i_wr && i_addr == 2'h0 && !i_wdata[2] |=> ##[1:2] o_count == 16'hFFFF)
    else $error("counter not preset");
  AST_COUNT_STEP: assert property (!i_wr && !$past(i_wr) && !$past(i_wr, 2) && o_count > 16'h0001
    |=> o_count == $past(o_count) || o_count == $past(o_count) - 16'h0001) else $error("bad count step");
  AST_UF_STICKY: assert property ($fell(o_underflow_flag) |-> $past(clr_uf) || $past(clr_uf, 2))
    else $error("underflow flag lost");
  AST_OVF_SET: assert property (i_acc_overflow |-> ##[1:2] o_overflow_flag)
    else $error("overflow flag not set");
  AST_IRQ_CAUSE: assert property (o_irq |-> cause || $past(cause))
    else $error("interrupt without cause");
  AST_IRQ_RAISE: assert property (cause |-> ##[0:2] o_irq)
    else $error("interrupt missing");
  cover property (o_irq);
  cover property ($rose(o_underflow_flag));
  cover property ($rose(o_overflow_flag));
endmodule // stall_counter_chk
bind stall_detector_modulus_counter stall_counter_chk #(.DIV_FAST(DIV_FAST), .DIV_SLOW(DIV_SLOW)) chk_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_acc_overflow(i_acc_overflow), .o_rdata(o_rdata), .o_irq(o_irq), .o_count(o_count),
  .o_underflow_flag(o_underflow_flag), .o_overflow_flag(o_overflow_flag));

// file: sim/stall_detector_modulus_counter_tb.sv
`timescale 1ns/100ps
module stall_detector_modulus_counter_tb;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_acc_overflow = 1'b0;
  reg [1:0] i_addr = 2'h0;
  reg [15:0] i_wdata = 16'h0000;
  wire [15:0] o_rdata;
  wire [15:0] o_count;
  wire o_irq;
  wire o_underflow_flag;
  wire o_overflow_flag;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer k;
  stall_detector_modulus_counter #(.DIV_FAST(4), .DIV_SLOW(8)) stall_detector_modulus_counter_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_acc_overflow(i_acc_overflow), .o_rdata(o_rdata), .o_irq(o_irq), .o_count(o_count),
    .o_underflow_flag(o_underflow_flag), .o_overflow_flag(o_overflow_flag));
  // Bus clock
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  task results;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string name, input [15:0] exp, input [15:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [1:0] a, input [15:0] d);
    begin
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input string name, input [1:0] a, input [15:0] exp);
    begin
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(name, exp, o_rdata);
    end
  endtask
  // Bounded wait for a counter value, k holds cycles taken
  task wcnt(input [15:0] v);
    begin
      k = 0;
      while (o_count !== v && k < 600) begin
        @(negedge i_clk);
        k = k + 1;
      end
      if (o_count !== v) begin
        chk("count wait", v, o_count);
        results;
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge i_clk);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rd("control", 2'h0, 16'h0000);
    rd("count preset", 2'h2, 16'hFFFF);
    rd("unmapped", 2'h3, 16'h0000);
    wr(2'h0, 16'h0014);
    wr(2'h2, 16'h0010);
    wcnt(16'h000E);
    wcnt(16'h000D);
    chk("slow period", 16'h0008, k[15:0]);
    wr(2'h0, 16'h0084);
    wcnt(16'h000A);
    wcnt(16'h0009);
    chk("period kept", 16'h0008, k[15:0]);
    wr(2'h2, 16'h0003);
    wcnt(16'h0002);
    wcnt(16'h0001);
    chk("fast period", 16'h0004, k[15:0]);
    wcnt(16'h0000);
    idle(3);
    chk("underflow irq", 16'h0001, {15'h0, o_irq});
    idle(20);
    chk("halt", 16'h0000, o_count);
    rd("flag set", 2'h1, 16'h0080);
    wr(2'h1, 16'h0000);
    rd("flag kept", 2'h1, 16'h0080);
    wr(2'h1, 16'h0080);
    rd("flag clear", 2'h1, 16'h0000);
    wr(2'h0, 16'h00A4);
    rd("load read", 2'h2, 16'h0003);
    wr(2'h0, 16'h000C);
    rd("force reads zero", 2'h0, 16'h0004);
    wcnt(16'h0001);
    wcnt(16'h0000);
    wr(2'h1, 16'h0080);
    wr(2'h2, 16'h0000);
    idle(12);
    chk("zero no flag", 16'h0000, {15'h0, o_underflow_flag});
    wr(2'h0, 16'h0000);
    idle(3);
    chk("disabled", 16'hFFFF, o_count);
    wr(2'h0, 16'h0040);
    wr(2'h2, 16'h0002);
    wr(2'h0, 16'h004C);
    wcnt(16'h0001);
    wcnt(16'h0002);
    chk("reload flag", 16'h0001, {15'h0, o_underflow_flag});
    wr(2'h0, 16'h0040);
    wr(2'h0, 16'h0000);
    wr(2'h1, 16'h0080);
    @(posedge i_clk);
    i_acc_overflow <= 1'b1;
    @(posedge i_clk);
    i_acc_overflow <= 1'b0;
    idle(3);
    chk("overflow flag", 16'h0001, {15'h0, o_overflow_flag});
    chk("masked irq", 16'h0000, {15'h0, o_irq});
    wr(2'h0, 16'h0001);
    idle(3);
    chk("overflow irq", 16'h0001, {15'h0, o_irq});
    wr(2'h1, 16'h0001);
    idle(3);
    chk("irq cleared", 16'h0000, {15'h0, o_irq});
    results;
  end
endmodule // stall_detector_modulus_counter_tb
